/* File: pmt_pkg.sv */
package pmt_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_FLAG = 8'h0c;
  localparam logic [7:0] OFF_ENABLE = 8'h10;
  // Reset values.
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [6:0] CONTROL_RST = 7'h00;
  // Field positions.
  localparam int CTL_POST_LSB = 3;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_PRE_LSB = 0;
  localparam int FLAG_MATCH_BIT = 1;
  // Last prescaler count for each division ratio.
  localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
  localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hf;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    PMT_SEL_NONE,
    PMT_SEL_COUNT,
    PMT_SEL_PERIOD,
    PMT_SEL_CONTROL,
    PMT_SEL_FLAG,
    PMT_SEL_ENABLE
  } pmt_sel_t;
  typedef struct packed {
    logic [3:0] post_divide_select;
    logic counter_run;
    logic [1:0] pre_divide_select;
  } pmt_ctrl_t;
endpackage

/* File: pmt_timer.sv */
`timescale 1ns/1ps
module pmt_timer #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk, // Instruction clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic match_out, // Unscaled match pulse
  output logic shift_clk, // Serial port shift clock
  output logic irq // Level interrupt
);
  import pmt_pkg::*;

  if (ADDR_W < 8)
  begin : g_chk
    $error("pmt_timer: ADDR_W must be at least 8");
  end

  function automatic pmt_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    pmt_sel_t s;
    s = PMT_SEL_NONE;
    if (a == ADDR_W'(OFF_COUNT))
      s = PMT_SEL_COUNT;
    else if (a == ADDR_W'(OFF_PERIOD))
      s = PMT_SEL_PERIOD;
    else if (a == ADDR_W'(OFF_CONTROL))
      s = PMT_SEL_CONTROL;
    else if (a == ADDR_W'(OFF_FLAG))
      s = PMT_SEL_FLAG;
    else if (a == ADDR_W'(OFF_ENABLE))
      s = PMT_SEL_ENABLE;
    return s;
  endfunction

  function automatic logic [3:0] pre_last(input logic [1:0] code);
    logic [3:0] v;
    case (code)
      2'b00: v = PRE_LAST_DIV1;
      2'b01: v = PRE_LAST_DIV4;
      default: v = PRE_LAST_DIV16;
    endcase
    return v;
  endfunction

  logic aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [7:0] count;
  logic [7:0] period;
  pmt_ctrl_t ctrl;
  logic flag;
  logic enable;
  logic [3:0] pre_cnt;
  logic [3:0] post_cnt;

  // Write channel: address and data are taken in either order.
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire next_aw_held = (aw_held && !wr_go) || aw_fire;
  wire next_w_held = (w_held && !wr_go) || w_fire;
  wire next_bvalid = wr_go || (s_axi_bvalid && !s_axi_bready);
  wire pmt_sel_t wr_sel = reg_sel(aw_addr_q);
  // Only byte lane 0 carries register bits; without it nothing changes.
  wire wr_lane = wr_go && w_strb_q[0];
  wire wr_count = wr_lane && (wr_sel == PMT_SEL_COUNT);
  wire wr_period = wr_lane && (wr_sel == PMT_SEL_PERIOD);
  wire wr_control = wr_lane && (wr_sel == PMT_SEL_CONTROL);
  wire wr_enable = wr_lane && (wr_sel == PMT_SEL_ENABLE);
  wire [7:0] wr_byte = w_data_q[7:0];

  // Read channel.
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
  wire pmt_sel_t rd_sel = reg_sel(s_axi_araddr);
  wire rd_flag_clear = ar_fire && (rd_sel == PMT_SEL_FLAG);
  wire ar_ctrl = ar_fire && (rd_sel == PMT_SEL_CONTROL);
  logic [7:0] rd_byte;
  always_comb
  begin
    case (rd_sel)
      PMT_SEL_COUNT: rd_byte = count;
      PMT_SEL_PERIOD: rd_byte = period;
      PMT_SEL_CONTROL: rd_byte = {1'b0, ctrl};
      PMT_SEL_FLAG: rd_byte = 8'(flag) << FLAG_MATCH_BIT;
      PMT_SEL_ENABLE: rd_byte = 8'(enable) << FLAG_MATCH_BIT;
      default: rd_byte = 8'h00;
    endcase
  end
  wire [1:0] rd_resp = (rd_sel == PMT_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
  wire [1:0] wr_resp = (wr_sel == PMT_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  // Timer core.
  wire run = ctrl.counter_run;
  wire scaler_clear = wr_count || wr_control;
  wire tick = run && (pre_cnt == pre_last(ctrl.pre_divide_select));
  wire hit = tick && (count == period);
  wire post_done = hit && (post_cnt == ctrl.post_divide_select);
  wire [3:0] next_pre_cnt = scaler_clear ? 4'h0 :
                            !run ? pre_cnt :
                            tick ? 4'h0 : pre_cnt + 4'h1;
  wire [7:0] next_count = wr_count ? wr_byte :
                          hit ? COUNT_RST :
                          tick ? count + 8'h01 : count;
  wire [3:0] next_post_cnt = scaler_clear ? 4'h0 :
                             post_done ? 4'h0 :
                             hit ? post_cnt + 4'h1 : post_cnt;
  // A completion in the cycle of a clearing read keeps the flag set.
  wire next_flag = post_done || (flag && !rd_flag_clear);
  wire next_enable = wr_enable ? wr_byte[FLAG_MATCH_BIT] : enable;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      s_axi_bvalid <= next_bvalid;
      if (aw_fire)
        aw_addr_q <= s_axi_awaddr;
      if (w_fire)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
        s_axi_bresp <= wr_resp;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_fire)
      begin
        s_axi_rdata <= {24'h0, rd_byte};
        s_axi_rresp <= rd_resp;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= COUNT_RST;
      period <= PERIOD_RST;
      ctrl <= CONTROL_RST;
      pre_cnt <= 4'h0;
      post_cnt <= 4'h0;
      flag <= 1'b0;
      enable <= 1'b0;
    end
    else
    begin
      count <= next_count;
      if (wr_period)
        period <= wr_byte;
      if (wr_control)
        ctrl <= wr_byte[6:0];
      pre_cnt <= next_pre_cnt;
      post_cnt <= next_post_cnt;
      flag <= next_flag;
      enable <= next_enable;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      match_out <= 1'b0;
      shift_clk <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      match_out <= hit;
      shift_clk <= shift_clk ^ hit;
      irq <= next_flag && next_enable;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_run_hold;
    !run && !wr_count |=> $stable(count);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("count moved while stopped");

  property p_match_eq;
    hit |-> count == period;
  endproperty
  a_match_eq: assert property (p_match_eq)
    else $error("match without equal values");

  property p_match_zero;
    hit && !wr_count |=> match_out && count == 8'h00;
  endproperty
  a_match_zero: assert property (p_match_zero)
    else $error("count not zero after match");

  property p_inc;
    tick && !hit && !wr_count |=> count == $past(count) + 8'h01;
  endproperty
  a_inc: assert property (p_inc)
    else $error("count did not step by one");

  property p_pre16;
    tick && ctrl.pre_divide_select[1] |-> pre_cnt == 4'hf;
  endproperty
  a_pre16: assert property (p_pre16)
    else $error("divide by 16 tick early");

  property p_post_step;
    hit && !post_done && !scaler_clear |=>
      post_cnt == $past(post_cnt) + 4'h1;
  endproperty
  a_post_step: assert property (p_post_step)
    else $error("postscaler missed a match");

  property p_flag_set;
    post_done |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set on completion");

  property p_flag_sticky;
    flag && !rd_flag_clear |=> flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without a clear");

  property p_irq_gate;
    irq |-> flag && enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enabled flag");

  property p_scaler_clr;
    scaler_clear |=> pre_cnt == 4'h0 && post_cnt == 4'h0;
  endproperty
  a_scaler_clr: assert property (p_scaler_clr)
    else $error("scalers not cleared by write");

  property p_ctrl_keep;
    wr_control && !wr_count && !tick |=> $stable(count);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("control write changed count");

  property p_wr_prio;
    wr_count |=> count == $past(wr_byte);
  endproperty
  a_wr_prio: assert property (p_wr_prio)
    else $error("count write lost");

  property p_msb_zero;
    ar_ctrl |=> s_axi_rdata[31:7] == 25'h0;
  endproperty
  a_msb_zero: assert property (p_msb_zero)
    else $error("control bit 7 read as one");

  property p_reset_vals;
    $rose(aresetn) |-> count == 8'h00 && period == 8'hff &&
      pre_cnt == 4'h0 && post_cnt == 4'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong values after reset");

  property p_shift_clk;
    hit |=> shift_clk != $past(shift_clk);
  endproperty
  a_shift_clk: assert property (p_shift_clk)
    else $error("shift clock did not toggle");

  property p_pre4;
    tick && ctrl.pre_divide_select == 2'b01 |-> pre_cnt == 4'h3;
  endproperty
  a_pre4: assert property (p_pre4)
    else $error("divide by 4 tick misplaced");

  property p_pre1;
    run && ctrl.pre_divide_select == 2'b00 |-> tick;
  endproperty
  a_pre1: assert property (p_pre1)
    else $error("direct input missed a tick");

  property p_halt_pre;
    !run && !scaler_clear |=> $stable(pre_cnt);
  endproperty
  a_halt_pre: assert property (p_halt_pre)
    else $error("prescaler moved while stopped");

  property p_irq_level;
    flag && enable |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("enabled flag without interrupt");

  property p_flag_clear;
    rd_flag_clear && !post_done |=> !flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by read");

  property p_wr_period;
    wr_period |=> period == $past(wr_byte);
  endproperty
  a_wr_period: assert property (p_wr_period)
    else $error("period write lost");

endmodule

/* File: tb_pmt_timer.sv */
`timescale 1ns/1ps
module tb_pmt_timer;
  import pmt_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, match_out, shift_clk, irq;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int n_checks = 0;
  int n_match = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (match_out === 1'b1) n_match <= n_match + 1;
  pmt_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .match_out(match_out), .shift_clk(shift_clk), .irq(irq));
  task close_out;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
      if (awvalid && awready === 1'b1) awvalid <= 0;
      if (wvalid && wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1 && k < 50);
    r = bresp;
    bready <= 0;
    if (k >= 50) chk(32'h1, 32'h0);
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
      if (arvalid && arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1 && k < 50);
    d = rdata;
    r = rresp;
    rready <= 0;
    if (k >= 50) chk(32'h1, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(32'(r), 32'(RESP_OKAY));
    chk(d, e);
  endtask
  task wait_match(output int k);
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
    end while (match_out !== 1'b1 && k < 400);
  endtask
  task t_reset;
    rd(OFF_COUNT, 32'h0);
    rd(OFF_PERIOD, 32'hff);
    rd(OFF_CONTROL, 32'h0);
    rd(OFF_FLAG, 32'h0);
    rd(OFF_ENABLE, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test reset done");
  endtask
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h20, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axr(8'h20, d, r);
    chk({d[29:0], r}, 32'(RESP_SLVERR));
    wr(OFF_CONTROL, 32'hff);
    rd(OFF_CONTROL, 32'h7f);
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_COUNT, 32'h42);
    wr(OFF_PERIOD, 32'h33);
    rd(OFF_PERIOD, 32'h33);
    wr(OFF_CONTROL, 32'h78);
    rd(OFF_COUNT, 32'h42);
    repeat (20) @(posedge aclk);
    rd(OFF_COUNT, 32'h42);
    $display("test registers done");
  endtask
  task t_period(input logic [1:0] c, input int div);
    int k;
    logic s;
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_PERIOD, 32'h3);
    wr(OFF_CONTROL, {29'h0, 1'b1, c});
    wait_match(k);
    s = shift_clk;
    wait_match(k);
    chk(32'(k), 32'(4 * div));
    chk(32'(shift_clk), 32'(!s));
    $display("test period code %0d done", c);
  endtask
  task t_post(input logic [3:0] s);
    int k, m;
    logic [31:0] d;
    logic [1:0] r;
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_PERIOD, 32'h7);
    wr(OFF_ENABLE, 32'h2);
    axr(OFF_FLAG, d, r);
    wr(OFF_CONTROL, {25'h0, s, 3'h4});
    m = 0;
    k = 0;
    do
    begin
      @(posedge aclk);
      k++;
      if (match_out === 1'b1) m++;
    end while (irq !== 1'b1 && k < 3000);
    chk(32'(m), 32'(s) + 32'h1);
    wait_match(k);
    wait_match(k);
    chk(32'(irq), 32'h1);
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_ENABLE, 32'h0);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    wr(OFF_ENABLE, 32'h2);
    @(posedge aclk);
    chk(32'(irq), 32'h1);
    rd(OFF_FLAG, 32'h2);
    rd(OFF_FLAG, 32'h0);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    $display("test postscale %0d done", s);
  endtask
  task t_clear;
    int base;
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_PERIOD, 32'h0);
    wr(OFF_CONTROL, 32'h6);
    wr(OFF_COUNT, 32'h0);
    base = n_match;
    repeat (4) wr(OFF_COUNT, 32'h0);
    chk(32'(n_match - base), 32'h0);
    base = n_match;
    repeat (4) wr(OFF_CONTROL, 32'h6);
    chk(32'(n_match - base), 32'h0);
    wr(OFF_CONTROL, 32'h0);
    $display("test scaler clear done");
  endtask
  task t_rst_mid;
    int k;
    wr(OFF_PERIOD, 32'h5);
    wr(OFF_ENABLE, 32'h2);
    wr(OFF_CONTROL, 32'h5);
    wait_match(k);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    $display("test mid-run reset done");
  endtask
  initial
  begin
    #500us;
    bad_count++;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_regs;
    t_period(2'h0, 1);
    t_period(2'h1, 4);
    t_period(2'h2, 16);
    t_period(2'h3, 16);
    t_post(4'h0);
    t_post(4'h3);
    t_post(4'hf);
    t_clear;
    t_rst_mid;
    close_out;
  end
endmodule
